// ### logic/dcs_burst_timer.v
`timescale 1ns/1ps
`include "dcs_consts.vh"

module dcs_burst_timer #(
    parameter [`DCS_CNT_W-2:0] BURST_CYCLES = `DCS_BURST_CYC
) (
    input  wire clk,
    input  wire rst,
    input  wire ce,
    input  wire start,
    input  wire double_len,
    input  wire abort,
    output wire tone_on,
    output wire busy,
    output reg  done
);

    // ----------------------------------------------------------------
    // burst then pause of equal length
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE  = `DCS_ST_IDLE;
    localparam [1:0] ST_BURST = `DCS_ST_BURST;
    localparam [1:0] ST_PAUSE = `DCS_ST_PAUSE;

    reg  [1:0]            state_q;
    reg  [`DCS_CNT_W-1:0] cnt_q;
    wire [`DCS_CNT_W-1:0] len;

    // length latched per phase, so a mode change mid-burst is seen late
    assign len = double_len ? {BURST_CYCLES, 1'b0} - 1'b1    // RL9
                            : {1'b0, BURST_CYCLES} - 1'b1;   // RL7
    assign tone_on = (state_q == ST_BURST);
    assign busy    = (state_q != ST_IDLE);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= {`DCS_CNT_W{1'b0}};
            done    <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (abort) begin
                state_q <= ST_IDLE;
                cnt_q   <= {`DCS_CNT_W{1'b0}};
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (start) begin
                            state_q <= ST_BURST;
                            cnt_q   <= len;
                        end
                    end
                    ST_BURST: begin
                        if (cnt_q == {`DCS_CNT_W{1'b0}}) begin
                            state_q <= ST_PAUSE;
                            cnt_q   <= len;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    ST_PAUSE: begin
                        if (cnt_q == {`DCS_CNT_W{1'b0}}) begin
                            state_q <= ST_IDLE;
                            done    <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ### logic/dcs_consts.vh
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH

// clock rate and burst timing
`define DCS_CLK_MHZ        100
`define DCS_BURST_MS       51
// 51 ms at 100 MHz, sized to the 24-bit burst length parameter
`define DCS_BURST_CYC      24'h4D_D1E0
`define DCS_CNT_W          25

// register select line values
`define DCS_RS_DATA        1'b0
`define DCS_RS_CTRL        1'b1

// control first field positions
`define DCS_A_TONE_ON      0
`define DCS_A_CP_SEL       1
`define DCS_A_IRQ_EN       2
`define DCS_A_SEL_SECOND   3

// control second field positions
`define DCS_B_BURST_OFF    0
`define DCS_B_RX_PD        1
`define DCS_B_SINGLE       2
`define DCS_B_COLUMN       3

// status field positions
`define DCS_S_IRQ          0
`define DCS_S_TX_EMPTY     1
`define DCS_S_RX_FULL      2
`define DCS_S_STEER        3

// reset values
`define DCS_CTRL_RST       4'h0
`define DCS_STAT_RST       4'h0
`define DCS_DATA_RST       4'h0
`define DCS_PIN_IDLE       9'h1_0F

// burst timer states
`define DCS_ST_IDLE        2'h0
`define DCS_ST_BURST       2'h1
`define DCS_ST_PAUSE       2'h2

`endif

// ### logic/dcs_regs.v
// Behaviour
// (RL1) tone output bit high drives tones; low powers down, floats pin, clears data
// (RL2) control first bit 1 selects call progress receive, else DTMF mode
// (RL3) call progress mode with interrupt enable puts received tone on pin
// (RL4) call progress mode detects no DTMF and reports no digit
// (RL5) DTMF mode interrupt on valid digit, and transmitter ready in burst
// (RL6) select bit routes next control write to second; then back to first
// (RL7) burst mode: each digit write gives burst and equal pause, 51 ms; a write during burst or pause starts none
// (RL8) end of burst pause sets transmit empty and may interrupt
// (RL9) call progress mode doubles burst and pause to 102 ms
// (RL10) burst off: tone output bit alone times each tone
// (RL11) receiver bit 0 enables both receivers; 1 powers them down
// (RL12) single tone when second bit 2 is 1, dual tone otherwise
// (RL13) single tone: column when second bit 3 is 1, row otherwise
// (RL14) transmitter and receivers both down stops oscillator and reference
// (RL15) status bit 0 follows bits 1 or 2; cleared by status read
// (RL16) transmit empty set at pause end; read clears; held clear burst off
// (RL17) receive full set on digit load; cleared by status read
// (RL18) delayed steering set on signal absence; cleared on valid signal
// (RL19) both control registers share one address, first by default
// (RL20) host makes one access per chip select falling edge
// (RL21) interrupt pin released after status read unless another is pending
`timescale 1ns/1ps
`include "dcs_consts.vh"

module dcs_regs #(
    parameter [`DCS_CNT_W-2:0] BURST_CYCLES = `DCS_BURST_CYC
) (
    input  wire       CLK_SYS,
    input  wire       RST,
    input  wire       CE,
    input  wire       CS_N,
    input  wire       RD_N,
    input  wire       WR_N,
    input  wire       REGISTER_SELECT_LINE,
    input  wire [3:0] D_IN,
    output reg  [3:0] D_OUT,
    output wire       D_OE,
    input  wire       RX_DIGIT_VALID,
    input  wire [3:0] RX_DIGIT,
    input  wire       RX_SIGNAL_LOST,
    input  wire       CP_TONE_IN,
    output wire       EVENT_OR_TONE_PIN_O,
    output wire       EVENT_OR_TONE_PIN_OE,
    output wire       TONE_OUTPUT_ON,
    output wire       TONE_PIN_OE,
    output wire       TONE_GEN_ACTIVE,
    output wire [3:0] TX_CODE,
    output wire       SINGLE_TONE,
    output wire       COLUMN_SELECT,
    output wire       CALL_PROGRESS_SELECT,
    output wire       RECEIVER_POWER_DOWN,
    output wire       OSC_STOP
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // every pin passes its own two flops; each stage resets to the idle
    // level of its pin, so leaving reset makes no false strobe
    localparam [8:0] pin_idle = `DCS_PIN_IDLE;

    wire [8:0] pins;
    wire [8:0] pins_s;
    genvar     gi;

    assign pins = {CP_TONE_IN, D_IN, REGISTER_SELECT_LINE, WR_N, RD_N, CS_N};

    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
            reg sync1_q;
            reg sync2_q;

            always @(posedge CLK_SYS or posedge RST) begin
                if (RST) begin
                    sync1_q <= pin_idle[gi];
                    sync2_q <= pin_idle[gi];
                end else if (CE) begin
                    sync1_q <= pins[gi];
                    sync2_q <= sync1_q;
                end
            end

            assign pins_s[gi] = sync2_q;
        end
    endgenerate

    wire       cs_s  = ~pins_s[0];
    wire       rd_s  = ~pins_s[1];
    wire       wr_s  = ~pins_s[2];
    wire       rs_s  = pins_s[3];
    wire [3:0] d_s   = pins_s[7:4];
    wire       cp_s  = pins_s[8];

    // ----------------------------------------------------------------
    // host strobes
    // ----------------------------------------------------------------
    // the access is acted on at the end of the strobe, so data has
    // settled through the synchroniser like the strobe itself
    reg        wr_act_q;
    reg        rd_act_q;
    reg        rs_lat_q;
    reg  [3:0] d_lat_q;
    wire       wr_act = cs_s & wr_s;
    wire       rd_act = cs_s & rd_s;
    wire       wr_end = wr_act_q & ~wr_act;
    wire       rd_end = rd_act_q & ~rd_act;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            rs_lat_q <= 1'b0;
            d_lat_q  <= `DCS_DATA_RST;
        end else if (CE) begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (wr_act) begin
                rs_lat_q <= rs_s;
                d_lat_q  <= d_s;
            end else if (rd_act) begin
                rs_lat_q <= rs_s;
            end
        end
    end

    // control and status share the select line high, data sits low
    function is_ctrl;
        input rs;
        begin
            is_ctrl = (rs == `DCS_RS_CTRL);
        end
    endfunction

    wire wr_ctrl = wr_end & is_ctrl(rs_lat_q);
    wire wr_data = wr_end & ~is_ctrl(rs_lat_q);
    wire rd_stat = rd_end & is_ctrl(rs_lat_q);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    reg  [3:0] ctrl_a_q;
    reg  [3:0] ctrl_b_q;
    reg        to_second_q;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_a_q    <= `DCS_CTRL_RST;
            ctrl_b_q    <= `DCS_CTRL_RST;
            to_second_q <= 1'b0;
        end else if (CE && wr_ctrl) begin
            if (to_second_q) begin
                ctrl_b_q    <= d_lat_q;
                to_second_q <= 1'b0;                              // RL6
            end else begin
                ctrl_a_q    <= d_lat_q;                           // RL19
                to_second_q <= d_lat_q[`DCS_A_SEL_SECOND];        // RL6
            end
        end
    end

    wire tone_en   = ctrl_a_q[`DCS_A_TONE_ON];
    wire cp_mode   = ctrl_a_q[`DCS_A_CP_SEL];
    wire irq_en    = ctrl_a_q[`DCS_A_IRQ_EN];
    wire burst_on  = ~ctrl_b_q[`DCS_B_BURST_OFF];
    wire rx_pd     = ctrl_b_q[`DCS_B_RX_PD];

    // oscillator stop only asks the clock source to halt; holding CE
    // low meanwhile is what keeps this block's state
    assign CALL_PROGRESS_SELECT = cp_mode;                        // RL2
    assign RECEIVER_POWER_DOWN  = rx_pd;                          // RL11
    assign SINGLE_TONE          = ctrl_b_q[`DCS_B_SINGLE];        // RL12
    assign COLUMN_SELECT        = ctrl_b_q[`DCS_B_COLUMN];        // RL13
    assign OSC_STOP             = ~tone_en & rx_pd;               // RL14

    // ----------------------------------------------------------------
    // transmit data and burst timing
    // ----------------------------------------------------------------
    reg  [3:0] tx_q;
    wire       burst_tone;
    wire       burst_busy;
    wire       burst_done;
    // a control write that clears the tone bit empties the transmit
    // register on the same edge, so the code never outlives the bit
    wire       tone_off_wr = wr_ctrl & ~to_second_q &
                             ~d_lat_q[`DCS_A_TONE_ON];

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tx_q <= `DCS_DATA_RST;
        end else if (CE) begin
            if (!tone_en || tone_off_wr) begin
                tx_q <= `DCS_DATA_RST;                            // RL1
            end else if (wr_data) begin
                tx_q <= d_lat_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // burst timing
    // ----------------------------------------------------------------
    // a digit written while a burst is still running is stored but
    // starts no second burst; software waits for transmit empty
    dcs_burst_timer #(
        .BURST_CYCLES (BURST_CYCLES)
    ) u_timer (
        .clk        (CLK_SYS),
        .rst        (RST),
        .ce         (CE),
        .start      (wr_data & tone_en & burst_on & ~burst_busy), // RL7
        .double_len (cp_mode),                                    // RL9
        .abort      (~tone_en | ~burst_on),
        .tone_on    (burst_tone),
        .busy       (burst_busy),
        .done       (burst_done)
    );

    assign TX_CODE         = tx_q;
    assign TONE_OUTPUT_ON  = tone_en;                             // RL1
    assign TONE_PIN_OE     = tone_en;                             // RL1
    assign TONE_GEN_ACTIVE = tone_en & (~burst_on | burst_tone);  // RL10

    // ----------------------------------------------------------------
    // receive data
    // ----------------------------------------------------------------
    reg  [3:0] rx_q;
    wire       rx_take = RX_DIGIT_VALID & ~cp_mode & ~rx_pd;      // RL4

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rx_q <= `DCS_DATA_RST;
        end else if (CE && rx_take) begin
            rx_q <= RX_DIGIT;
        end
    end

    // ----------------------------------------------------------------
    // status register
    // ----------------------------------------------------------------
    // a set landing in the same cycle as the read clear wins, so an
    // event at the end of a status read is kept for the next read
    function next_flag;
        input cur;
        input set;
        input clr;
        begin
            if (set) begin
                next_flag = 1'b1;
            end else if (clr) begin
                next_flag = 1'b0;
            end else begin
                next_flag = cur;
            end
        end
    endfunction

    reg  [3:0] stat_q;
    wire [3:0] stat_d;
    wire       tx_set    = burst_done & burst_on;                 // RL8
    wire       rx_set    = rx_take;
    wire       steer_set = RX_SIGNAL_LOST & ~cp_mode & ~rx_pd;

    assign stat_d[`DCS_S_IRQ]      = next_flag(stat_q[`DCS_S_IRQ],
                                               tx_set | rx_set,
                                               rd_stat);          // RL15
    assign stat_d[`DCS_S_TX_EMPTY] = burst_on &                   // RL16
                                     next_flag(stat_q[`DCS_S_TX_EMPTY],
                                               tx_set, rd_stat);
    assign stat_d[`DCS_S_RX_FULL]  = next_flag(stat_q[`DCS_S_RX_FULL],
                                               rx_set, rd_stat);  // RL17
    assign stat_d[`DCS_S_STEER]    = next_flag(stat_q[`DCS_S_STEER],
                                               steer_set,
                                               rx_take);          // RL18

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            stat_q <= `DCS_STAT_RST;
        end else if (CE) begin
            stat_q <= stat_d;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // reloaded every cycle of the strobe, so it stands until release
    wire [3:0] rd_data = is_ctrl(rs_s) ? stat_q : rx_q;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            D_OUT <= `DCS_DATA_RST;
        end else if (CE && rd_act) begin
            D_OUT <= rd_data;
        end
    end

    assign D_OE = rd_act_q & rd_act;

    // ----------------------------------------------------------------
    // open-drain interrupt / tone pin
    // ----------------------------------------------------------------
    wire irq_low = irq_en & ~cp_mode & stat_q[`DCS_S_IRQ];        // RL5 RL21
    wire cp_low  = irq_en & cp_mode & ~rx_pd & ~cp_s;             // RL3

    assign EVENT_OR_TONE_PIN_O  = 1'b0;
    assign EVENT_OR_TONE_PIN_OE = irq_low | cp_low;

endmodule

// ### test/dcs_host_model.sv
`timescale 1ns/1ps
module dcs_host_model (
    input  wire       clk,
    input  wire [3:0] d_out,
    output reg        cs_n,
    output reg        rd_n,
    output reg        wr_n,
    output reg        rs,
    output reg  [3:0] d_in
);
    // ---------------------------------------
    // host bus cycle
    // ---------------------------------------
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        rs = 1'b1;
        d_in = 4'h0;
    end

    // strobes held six cycles: the pins pass a two-flop sync
    task acc(input w, input r, input [3:0] d, output [3:0] q);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        rd_n = w;
        wr_n = !w;
        rs = r;
        d_in = d;
        repeat (6) @(posedge clk);
        #1;
        q = d_out;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        // released bus must not keep the old value
        d_in = ~d;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule

// ### test/dcs_regs_chk.sv
`timescale 1ns/1ps
module dcs_regs_chk #(
    parameter [23:0] BURST_CYCLES = 24'h0014
) (
    input wire       CLK_SYS,
    input wire       RST,
    input wire       RD_N,
    input wire       REGISTER_SELECT_LINE,
    input wire       D_OE,
    input wire       RX_DIGIT_VALID,
    input wire       CP_TONE_IN,
    input wire       EVENT_OR_TONE_PIN_O,
    input wire       EVENT_OR_TONE_PIN_OE,
    input wire       TONE_OUTPUT_ON,
    input wire       TONE_PIN_OE,
    input wire       TONE_GEN_ACTIVE,
    input wire [3:0] TX_CODE,
    input wire       CALL_PROGRESS_SELECT,
    input wire       RECEIVER_POWER_DOWN,
    input wire       OSC_STOP
);
    // ---------------------------------------
    // tone run length helper
    // ---------------------------------------
    reg  [24:0] run_q;
    wire [24:0] run_d = TONE_GEN_ACTIVE ? run_q + 25'h1 : 25'h0;
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST)
            run_q <= 25'h0;
        else
            run_q <= run_d;
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    chk_pin_open_drain: assert property (!EVENT_OR_TONE_PIN_O)
        else $error("event pin driven high");
    chk_tone_pin_float: assert property (TONE_PIN_OE == TONE_OUTPUT_ON)
        else $error("tone pin enable mismatch");
    chk_tx_cleared: assert property (!TONE_OUTPUT_ON |-> TX_CODE == 4'h0)
        else $error("transmit code kept while off");
    chk_gen_off: assert property (!TONE_OUTPUT_ON |-> !TONE_GEN_ACTIVE)
        else $error("tone active while off");
    chk_osc_stop: assert property
        (OSC_STOP == (!TONE_OUTPUT_ON && RECEIVER_POWER_DOWN))
        else $error("oscillator stop mismatch");
    chk_cp_follow: assert property (CALL_PROGRESS_SELECT &&
        !RECEIVER_POWER_DOWN && EVENT_OR_TONE_PIN_OE |->
        !$past(CP_TONE_IN, 2))
        else $error("pin low without received tone");
    chk_read_drive: assert property (D_OE |->
        !$past(RD_N, 2) && !$past(RD_N, 3))
        else $error("bus driven without read");
    chk_burst_len: assert property ($fell(TONE_GEN_ACTIVE) &&
        TONE_OUTPUT_ON |-> run_q ==
        (CALL_PROGRESS_SELECT ? 2 * BURST_CYCLES : BURST_CYCLES))
        else $error("burst length wrong");
    chk_irq_release: assert property ($rose(RD_N) &&
        REGISTER_SELECT_LINE && !CALL_PROGRESS_SELECT &&
        !RX_DIGIT_VALID |-> ##[3:6] !EVENT_OR_TONE_PIN_OE)
        else $error("event pin held after status read");
endmodule

bind dcs_regs dcs_regs_chk #(.BURST_CYCLES(BURST_CYCLES)) u_chk (.*);

// ### test/test_dcs_regs.sv
`timescale 1ns/1ps
`define CK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    err_count++; $display("unexpected %s exp %h got %h", n, e, a); \
    end end
module test_dcs_regs;
    localparam [23:0] BC = 24'h0014;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        dv = 1'b0;
    reg        lost = 1'b0;
    reg        cpt = 1'b1;
    reg  [3:0] dg = 4'h0;
    reg  [3:0] q;
    wire       cs_n;
    wire       rd_n;
    wire       wr_n;
    wire       rs;
    wire [3:0] d_in;
    wire [3:0] d_out;
    integer    err_count = 0;
    integer    comparisons = 0;
    integer    cyc = 0;

    always #5 clk = ~clk;

    dcs_host_model HOST (.clk(clk), .d_out(d_out), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .rs(rs), .d_in(d_in));

    dcs_regs #(.BURST_CYCLES(BC)) DUT (.CLK_SYS(clk), .RST(rst),
        .CE(1'b1), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .REGISTER_SELECT_LINE(rs), .D_IN(d_in), .D_OUT(d_out),
        .D_OE(), .RX_DIGIT_VALID(dv), .RX_DIGIT(dg),
        .RX_SIGNAL_LOST(lost), .CP_TONE_IN(cpt),
        .EVENT_OR_TONE_PIN_O(), .EVENT_OR_TONE_PIN_OE(),
        .TONE_OUTPUT_ON(), .TONE_PIN_OE(), .TONE_GEN_ACTIVE(),
        .TX_CODE(), .SINGLE_TONE(), .COLUMN_SELECT(),
        .CALL_PROGRESS_SELECT(), .RECEIVER_POWER_DOWN(), .OSC_STOP());

    // ---------------------------------------
    // helpers
    // ---------------------------------------
    task wr(input r, input [3:0] d);
        HOST.acc(1'b1, r, d, q);
    endtask
    task rd(input r, input [3:0] e);
        HOST.acc(1'b0, r, 4'h0, q);
        `CK("read", e, q)
    endtask
    task w(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task pulse(input l, input [3:0] d);
        @(posedge clk);
        #1;
        dv = !l;
        lost = l;
        dg = d;
        @(posedge clk);
        #1;
        dv = 1'b0;
        lost = 1'b0;
        w(2);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ---------------------------------------
    // scenarios
    // ---------------------------------------
    task t_reset;
        `CK("tone", 1'b0, DUT.TONE_OUTPUT_ON)
        `CK("osc", 1'b0, DUT.OSC_STOP)
        rd(1'b1, 4'h0);
        $display("test reset done");
    endtask
    task t_ctrl;
        wr(1'b1, 4'h8);
        wr(1'b1, 4'hE);
        `CK("single", 1'b1, DUT.SINGLE_TONE)
        `CK("column", 1'b1, DUT.COLUMN_SELECT)
        `CK("rxpd", 1'b1, DUT.RECEIVER_POWER_DOWN)
        `CK("osc", 1'b1, DUT.OSC_STOP)
        wr(1'b1, 4'h3);
        `CK("cp", 1'b1, DUT.CALL_PROGRESS_SELECT)
        `CK("single", 1'b1, DUT.SINGLE_TONE)
        `CK("osc", 1'b0, DUT.OSC_STOP)
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
        `CK("single", 1'b0, DUT.SINGLE_TONE)
        `CK("rxpd", 1'b0, DUT.RECEIVER_POWER_DOWN)
        `CK("column", 1'b0, DUT.COLUMN_SELECT)
        $display("test control done");
    endtask
    task t_rx;
        wr(1'b1, 4'h4);
        pulse(1'b0, 4'h9);
        `CK("irq", 1'b1, DUT.EVENT_OR_TONE_PIN_OE)
        rd(1'b1, 4'h5);
        `CK("irq", 1'b0, DUT.EVENT_OR_TONE_PIN_OE)
        rd(1'b0, 4'h9);
        pulse(1'b1, 4'h0);
        rd(1'b1, 4'h8);
        pulse(1'b0, 4'h2);
        rd(1'b1, 4'h5);
        $display("test receive done");
    endtask
    task t_cp;
        wr(1'b1, 4'h6);
        pulse(1'b0, 4'h1);
        rd(1'b1, 4'h0);
        rd(1'b0, 4'h2);
        cpt = 1'b0;
        w(5);
        `CK("cp pin", 1'b1, DUT.EVENT_OR_TONE_PIN_OE)
        cpt = 1'b1;
        w(5);
        `CK("cp pin", 1'b0, DUT.EVENT_OR_TONE_PIN_OE)
        $display("test call progress done");
    endtask
    task t_burst;
        wr(1'b1, 4'h5);
        wr(1'b0, 4'h7);
        `CK("code", 4'h7, DUT.TX_CODE)
        `CK("gen", 1'b1, DUT.TONE_GEN_ACTIVE)
        w(50);
        `CK("irq", 1'b1, DUT.EVENT_OR_TONE_PIN_OE)
        rd(1'b1, 4'h3);
        wr(1'b1, 4'h7);
        wr(1'b0, 4'h5);
        w(100);
        rd(1'b1, 4'h3);
        $display("test burst done");
    endtask
    task t_free;
        wr(1'b1, 4'h9);
        wr(1'b1, 4'h1);
        `CK("gen", 1'b1, DUT.TONE_GEN_ACTIVE)
        wr(1'b0, 4'h3);
        w(60);
        rd(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        `CK("gen", 1'b0, DUT.TONE_GEN_ACTIVE)
        `CK("code", 4'h0, DUT.TX_CODE)
        `CK("tone oe", 1'b0, DUT.TONE_PIN_OE)
        $display("test free tone done");
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        w(2);
        t_reset;
        t_ctrl;
        t_rx;
        t_cp;
        t_burst;
        t_free;
        final_report;
    end
endmodule
